// File: ptm_timer.sv
// The Avalon-MM interface to the registers and the address map are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module ptm_timer #(
  parameter bit WIDE = 1'b1
) (
  // Clock, reset and enable
  input  wire logic        mclk_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // Avalon-MM slave
  input  wire logic [3:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  output logic [31:0]      avs_readdata_out,
  output logic             avs_waitrequest_out,
  // Timer pins
  input  wire logic        tick_in,
  input  wire logic        capture_pin_in,
  input  wire logic        external_trigger_pin_in,
  input  wire logic        noise_filter_input_in,
  output logic             timer_out,
  output logic             timer_irq_out
);
  localparam logic [15:0] CNT_MAX = WIDE ? 16'hFFFF : 16'h03FF;

  typedef struct packed {
    ptm_pkg::ptm_bus_e bus;
    logic [31:0]       rdata;
    logic [9:0]        ctrl;
    logic [15:0]       period_compare_value;
    logic [15:0]       duty_compare_value;
    logic [15:0]       count;
    logic [15:0]       capture;
    logic              duty_match_flag;
    logic              period_match_flag;
    logic              pin;
    logic              run_prev;
    logic              nf_s0;
    logic              nf_s1;
    logic              nf_prev;
  } ptm_state_s;

  ptm_state_s st_q;
  ptm_state_s st_d;
  ptm_evt_if  evt ();

  ptm_edge_sync u_sync (
    .mclk_in    (mclk_in),
    .sys_rst_in (sys_rst_in),
    .clk_en_in  (clk_en_in),
    .evt        (evt)
  );
  assign evt.cap_raw  = capture_pin_in;
  assign evt.trig_raw = external_trigger_pin_in;

  logic [1:0]  mode;
  logic [1:0]  pinf;
  logic        run;
  logic        run_rise;
  logic        tick;
  logic        duty_hit;
  logic        per_hit;
  logic        cap_r;
  logic        cap_f;
  logic        cap_evt;
  logic        wr;
  logic [15:0] wmask;
  logic        pwm_act;
  logic [15:0] cnt_next;
  logic [31:0] rd;

  assign mode     = st_q.ctrl[ptm_pkg::CTRL_MODE_LO +: 2];
  assign pinf     = st_q.ctrl[ptm_pkg::CTRL_PINF_LO +: 2];
  assign run      = st_q.ctrl[ptm_pkg::CTRL_RUN];
  assign run_rise = run & ~st_q.run_prev;
  assign tick     = tick_in & run;
  assign wmask    = CNT_MAX;
  assign wr       = avs_write_in && (st_q.bus == ptm_pkg::BUS_ACK);
  assign cnt_next = (st_q.count == CNT_MAX) ? 16'h0000 : st_q.count + 16'h0001;
  // Matches are detected on the registered count, so a flag appears one tick late.
  assign duty_hit = (st_q.duty_compare_value != 16'h0000) &&
                    (st_q.count == st_q.duty_compare_value);
  assign per_hit  = (st_q.count == ((st_q.period_compare_value == 16'h0000) ?
                    CNT_MAX : st_q.period_compare_value - 16'h0001));

  always_comb begin
    // Capture source: noise filter if selected, else pin or trigger.
    cap_r = st_q.ctrl[ptm_pkg::CTRL_NF_SEL] ? (st_q.nf_s1 & ~st_q.nf_prev) :
            st_q.ctrl[ptm_pkg::CTRL_CAP_SRC] ? evt.trig_rise : evt.cap_rise;
    cap_f = st_q.ctrl[ptm_pkg::CTRL_NF_SEL] ? (~st_q.nf_s1 & st_q.nf_prev) :
            st_q.ctrl[ptm_pkg::CTRL_CAP_SRC] ? 1'b0 : evt.cap_fall;
    case (pinf)
      ptm_pkg::CAPE_RISE: cap_evt = cap_r;
      ptm_pkg::CAPE_FALL: cap_evt = cap_f;
      ptm_pkg::CAPE_BOTH: cap_evt = cap_r | cap_f;
      default:            cap_evt = 1'b0;
    endcase
  end

  // PWM active while count is below duty; duty at or above period means always on.
  // A zero period spans the full counter range, which no duty value can reach.
  assign pwm_act = ((st_q.period_compare_value != 16'h0000) &&
                    (st_q.duty_compare_value >= st_q.period_compare_value)) ||
                   (st_q.count < st_q.duty_compare_value);

  always_comb begin
    st_d = st_q;
    st_d.run_prev = run;
    st_d.nf_s0    = noise_filter_input_in;
    st_d.nf_s1    = st_q.nf_s0;
    st_d.nf_prev  = st_q.nf_s1;
    // Write one to clear comes first, so a hardware set later in this cycle wins.
    if (wr && avs_address_in == ptm_pkg::ADDR_STATUS) begin
      if (avs_writedata_in[ptm_pkg::STAT_DUTY]) st_d.duty_match_flag = 1'b0;
      if (avs_writedata_in[ptm_pkg::STAT_PERIOD]) st_d.period_match_flag = 1'b0;
    end
    // Single pulse auto start from the trigger pin.
    if (mode == ptm_pkg::MODE_PWM && pinf == ptm_pkg::PINF_TOGGLE && evt.trig_rise) begin
      st_d.ctrl[ptm_pkg::CTRL_RUN] = 1'b1;
    end
    if (run_rise) begin
      st_d.count = 16'h0000;
      st_d.pin   = st_q.ctrl[ptm_pkg::CTRL_OUT_CTL];
    end else if (tick) begin
      case (mode)
        ptm_pkg::MODE_COMPARE, ptm_pkg::MODE_TIMER: begin
          if (st_q.ctrl[ptm_pkg::CTRL_CLR_SEL]) begin
            st_d.count = duty_hit ? 16'h0000 : cnt_next;
          end else begin
            st_d.count = per_hit ? 16'h0000 : cnt_next;
            if (per_hit) st_d.period_match_flag = 1'b1;
          end
          if (duty_hit) begin
            st_d.duty_match_flag = 1'b1;
            if (mode == ptm_pkg::MODE_COMPARE) begin
              case (pinf)
                ptm_pkg::PINF_LOW:    st_d.pin = 1'b0;
                ptm_pkg::PINF_HIGH:   st_d.pin = 1'b1;
                ptm_pkg::PINF_TOGGLE: st_d.pin = ~st_q.pin;
                default:              st_d.pin = st_q.pin;
              endcase
            end
          end
        end
        ptm_pkg::MODE_PWM: begin
          if (pinf == ptm_pkg::PINF_TOGGLE) begin
            st_d.count = cnt_next;
            if (duty_hit) begin
              st_d.duty_match_flag = 1'b1;
              st_d.ctrl[ptm_pkg::CTRL_RUN] = 1'b0;
            end
          end else begin
            st_d.count = per_hit ? 16'h0000 : cnt_next;
            if (per_hit) st_d.period_match_flag = 1'b1;
            if (duty_hit) st_d.duty_match_flag = 1'b1;
          end
        end
        default: begin
          st_d.count = per_hit ? 16'h0000 : cnt_next;
          if (per_hit) st_d.period_match_flag = 1'b1;
        end
      endcase
    end
    if (mode == ptm_pkg::MODE_CAPTURE && run && cap_evt) begin
      st_d.capture = st_q.count;
      st_d.duty_match_flag = 1'b1;
    end
    // Bus slave: one wait state, then the answer.
    case (st_q.bus)
      ptm_pkg::BUS_IDLE: begin
        if (avs_read_in || avs_write_in) st_d.bus = ptm_pkg::BUS_ACK;
      end
      ptm_pkg::BUS_ACK: st_d.bus = ptm_pkg::BUS_IDLE;
      default:          st_d.bus = ptm_pkg::BUS_IDLE;
    endcase
    if (avs_read_in && st_q.bus == ptm_pkg::BUS_IDLE) st_d.rdata = rd;
    if (wr) begin
      case (avs_address_in)
        ptm_pkg::ADDR_CTRL:   st_d.ctrl = avs_writedata_in[9:0];
        ptm_pkg::ADDR_PERIOD: st_d.period_compare_value = avs_writedata_in[15:0] & wmask;
        ptm_pkg::ADDR_DUTY:   st_d.duty_compare_value = avs_writedata_in[15:0] & wmask;
        default: st_d.bus = st_d.bus;
      endcase
    end
  end

  always_comb begin
    rd = 32'h0000_0000;
    case (avs_address_in)
      ptm_pkg::ADDR_CTRL:    rd[9:0] = st_q.ctrl;
      ptm_pkg::ADDR_STATUS:  rd[2:0] = {st_q.pin, st_q.period_match_flag,
                                        st_q.duty_match_flag};
      ptm_pkg::ADDR_PERIOD:  rd[15:0] = st_q.period_compare_value;
      ptm_pkg::ADDR_DUTY:    rd[15:0] = st_q.duty_compare_value;
      ptm_pkg::ADDR_COUNT:   rd[15:0] = st_q.count;
      ptm_pkg::ADDR_CAPTURE: rd[15:0] = st_q.capture;
      default:               rd = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
      st_q.bus <= ptm_pkg::BUS_IDLE;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end

  always_comb begin
    timer_out = st_q.pin;
    if (mode == ptm_pkg::MODE_PWM) begin
      case (pinf)
        ptm_pkg::PINF_NONE:   timer_out = ~st_q.ctrl[ptm_pkg::CTRL_OUT_CTL];
        ptm_pkg::PINF_LOW:    timer_out = st_q.ctrl[ptm_pkg::CTRL_OUT_CTL];
        ptm_pkg::PINF_HIGH:   timer_out = pwm_act ~^ st_q.ctrl[ptm_pkg::CTRL_OUT_CTL];
        default:              timer_out = run ~^ st_q.ctrl[ptm_pkg::CTRL_OUT_CTL];
      endcase
    end else if (mode != ptm_pkg::MODE_COMPARE) begin
      timer_out = 1'b0;
    end
    timer_out = timer_out ^ st_q.ctrl[ptm_pkg::CTRL_INVERT];
  end

  assign timer_irq_out       = st_q.duty_match_flag | st_q.period_match_flag;
  assign avs_readdata_out    = st_q.rdata;
  assign avs_waitrequest_out = (avs_read_in | avs_write_in) && (st_q.bus != ptm_pkg::BUS_ACK);
endmodule
`default_nettype wire

// File: ptm_pkg.sv
// How it works
// - Compare mode: clear on period match, both flags.
// - Clear-select high: clear on duty, duty flag only.
// - Period zero: overflow at maximum; duty zero: no duty flag.
// - Pin changes only on duty match or run bit rise in compare.
// - Pin function: none, low, high, toggle.
// - Run bit rise restores initial output level.
// - Timer/counter mode counts like compare, pin unused.
// - PWM: period match clears, duty sets width.
// - Period zero gives full-range PWM period.
// - Duty at or above period gives 100%.
// - PWM counting continues while pin forced.
// - PWM flags per match; level and invert bits.
// - Single pulse starts on run rise or trigger.
// - Duty match ends pulse, clears run, interrupts.
// - Single pulse: counter zeroed only at run rise.
// - Capture source: pin, trigger or filter output.
// - Capture edge: rising, falling, both, disabled; trigger source captures rising edges only.
// - Capture edge latches counter and interrupts.
// - Narrow instances: period value 10 bits wide.
`default_nettype none
package ptm_pkg;
  localparam logic [3:0] ADDR_CTRL    = 4'h0;
  localparam logic [3:0] ADDR_STATUS  = 4'h1;
  localparam logic [3:0] ADDR_PERIOD  = 4'h2;
  localparam logic [3:0] ADDR_DUTY    = 4'h3;
  localparam logic [3:0] ADDR_COUNT   = 4'h4;
  localparam logic [3:0] ADDR_CAPTURE = 4'h5;
  localparam int CTRL_RUN     = 0;
  localparam int CTRL_CLR_SEL = 1;
  localparam int CTRL_CAP_SRC = 2;
  localparam int CTRL_INVERT  = 3;
  localparam int CTRL_OUT_CTL = 4;
  localparam int CTRL_PINF_LO = 5;
  localparam int CTRL_MODE_LO = 7;
  localparam int CTRL_NF_SEL  = 9;
  localparam int STAT_DUTY    = 0;
  localparam int STAT_PERIOD  = 1;
  localparam int STAT_PIN     = 2;
  localparam logic [1:0] MODE_COMPARE = 2'h0;
  localparam logic [1:0] MODE_CAPTURE = 2'h1;
  localparam logic [1:0] MODE_PWM     = 2'h2;
  localparam logic [1:0] MODE_TIMER   = 2'h3;
  localparam logic [1:0] PINF_NONE    = 2'h0;
  localparam logic [1:0] PINF_LOW     = 2'h1;
  localparam logic [1:0] PINF_HIGH    = 2'h2;
  localparam logic [1:0] PINF_TOGGLE  = 2'h3;
  localparam logic [1:0] CAPE_RISE    = 2'h0;
  localparam logic [1:0] CAPE_FALL    = 2'h1;
  localparam logic [1:0] CAPE_BOTH    = 2'h2;
  localparam logic [9:0] CTRL_RESET   = 10'h000;
  localparam logic [15:0] VAL_RESET   = 16'h0000;
  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_ACK  = 2'b10
  } ptm_bus_e;
endpackage
`default_nettype wire

// File: ptm_evt_if.sv
`timescale 1ns/10ps
`default_nettype none
interface ptm_evt_if;
  logic cap_raw;
  logic trig_raw;
  logic cap_rise;
  logic cap_fall;
  logic trig_rise;
  modport sync (input cap_raw, input trig_raw, output cap_rise, output cap_fall,
                output trig_rise);
  modport core (output cap_raw, output trig_raw, input cap_rise, input cap_fall,
                input trig_rise);
endinterface
`default_nettype wire

// File: ptm_edge_sync.sv
`timescale 1ns/10ps
`default_nettype none
module ptm_edge_sync (
  // Clock and reset
  input  wire logic mclk_in,
  input  wire logic sys_rst_in,
  input  wire logic clk_en_in,
  // Events
  ptm_evt_if.sync   evt
);
  typedef struct packed {
    logic [1:0] cap_sync;
    logic [1:0] trig_sync;
    logic       cap_prev;
    logic       trig_prev;
  } ptm_sync_s;
  ptm_sync_s st_q;
  ptm_sync_s st_d;
  always_comb begin
    st_d = st_q;
    st_d.cap_sync  = {st_q.cap_sync[0], evt.cap_raw};
    st_d.trig_sync = {st_q.trig_sync[0], evt.trig_raw};
    st_d.cap_prev  = st_q.cap_sync[1];
    st_d.trig_prev = st_q.trig_sync[1];
  end
  always_ff @(posedge mclk_in or posedge sys_rst_in) begin
    if (sys_rst_in) begin
      st_q <= '0;
    end else if (clk_en_in) begin
      st_q <= st_d;
    end
  end
  assign evt.cap_rise  = st_q.cap_sync[1] & ~st_q.cap_prev;
  assign evt.cap_fall  = ~st_q.cap_sync[1] & st_q.cap_prev;
  assign evt.trig_rise = st_q.trig_sync[1] & ~st_q.trig_prev;
endmodule
`default_nettype wire

// File: ptm_timer_props.sv
`timescale 1ns/10ps
`default_nettype none
module ptm_timer_props #(
  parameter bit WIDE = 1'b1
) (
  // Watched ports
  input wire logic        mclk_in,
  input wire logic        sys_rst_in,
  input wire logic        clk_en_in,
  input wire logic [3:0]  avs_address_in,
  input wire logic        avs_read_in,
  input wire logic        avs_write_in,
  input wire logic [31:0] avs_readdata_out,
  input wire logic        avs_waitrequest_out,
  input wire logic        timer_out,
  input wire logic        timer_irq_out
);
  default clocking @(posedge mclk_in); endclocking
  default disable iff (sys_rst_in);
  wire logic rd_ack = avs_read_in && !avs_waitrequest_out;
  chk_one_wait: assert property ((avs_read_in || avs_write_in) && avs_waitrequest_out
    |=> !avs_waitrequest_out) else $error("wait state too long");
  chk_req_waits: assert property ($rose(avs_read_in) |-> avs_waitrequest_out)
    else $error("read answered at once");
  chk_idle_free: assert property (!avs_read_in && !avs_write_in |-> !avs_waitrequest_out)
    else $error("waitrequest while idle");
  chk_unmapped_zero: assert property (rd_ack && avs_address_in > 4'h5 |-> avs_readdata_out == 32'h0)
    else $error("unmapped read not zero");
  chk_upper_zero: assert property (rd_ack |-> avs_readdata_out[31:16] == 16'h0000)
    else $error("unused bits set");
  chk_narrow_zero: assert property (rd_ack && !WIDE && avs_address_in inside {[4'h2:4'h5]}
    |-> avs_readdata_out[15:10] == 6'h00) else $error("narrow value too wide");
  chk_irq_clear: assert property ($fell(timer_irq_out) |-> $past(avs_write_in))
    else $error("interrupt dropped without a write");
  chk_freeze_hold: assert property (!clk_en_in |=> $stable(timer_out) && $stable(timer_irq_out))
    else $error("state moved while frozen");
  chk_reset_quiet: assert property ($fell(sys_rst_in) |-> !timer_out && !timer_irq_out)
    else $error("outputs not clear after reset");
endmodule
bind ptm_timer ptm_timer_props #(.WIDE(WIDE)) u_ptm_timer_props (.mclk_in, .sys_rst_in,
  .clk_en_in, .avs_address_in, .avs_read_in, .avs_write_in, .avs_readdata_out,
  .avs_waitrequest_out, .timer_out, .timer_irq_out);
`default_nettype wire

// File: ptm_pin_model.sv
`timescale 1ns/10ps
`default_nettype none
module ptm_pin_model (
  // Clock
  input  wire logic mclk_in,
  // Pins toward the timer
  output logic      cap_out,
  output logic      trig_out,
  output logic      filt_out
);
  // Sets one source after a lag in clocks, so the far side answers promptly or slowly.
  task automatic drive(input int src, input logic lvl, input int lag);
    repeat (lag) @(posedge mclk_in);
    if (src == 0) cap_out <= lvl;
    else if (src == 1) trig_out <= lvl;
    else filt_out <= lvl;
  endtask
  initial begin
    cap_out = 1'b0;
    trig_out = 1'b0;
    filt_out = 1'b0;
  end
endmodule
`default_nettype wire

// File: tb.sv
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        mclk_in, sys_rst_in, clk_en_in, tick_in, rd, wr, wt, tmr, irq, oc;
  logic        cap_p, trg_p, flt_p;
  logic [3:0]  adr;
  logic [31:0] wd, rdat, v, c, cw;
  logic [15:0] p, d;
  int          err_total, checked, seed, t, h, i, n;
  ptm_timer #(.WIDE(1'b0)) u_ptm_timer (.mclk_in, .sys_rst_in, .clk_en_in, .tick_in,
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wd),
    .avs_readdata_out(rdat), .avs_waitrequest_out(wt), .capture_pin_in(cap_p),
    .external_trigger_pin_in(trg_p), .noise_filter_input_in(flt_p), .timer_out(tmr),
    .timer_irq_out(irq));
  ptm_pin_model u_ptm_pin_model (.mclk_in, .cap_out(cap_p), .trig_out(trg_p), .filt_out(flt_p));
  function automatic logic [31:0] ctl(input logic [1:0] m, f, input logic iv, cs,
                                      input logic [1:0] src);
    ctl = 32'h0;
    ctl[ptm_pkg::CTRL_RUN] = 1'b1;
    ctl[ptm_pkg::CTRL_MODE_LO +: 2] = m;
    ctl[ptm_pkg::CTRL_PINF_LO +: 2] = f;
    ctl[ptm_pkg::CTRL_OUT_CTL] = oc;
    ctl[ptm_pkg::CTRL_INVERT] = iv;
    ctl[ptm_pkg::CTRL_CLR_SEL] = cs;
    ctl[ptm_pkg::CTRL_CAP_SRC] = src[0];
    ctl[ptm_pkg::CTRL_NF_SEL] = src[1];
  endfunction
  function automatic logic ep(input logic [1:0] f, input logic o);
    ep = (f == 2'h0) ? o : (f == 2'h1) ? 1'b0 : (f == 2'h2) ? 1'b1 : !o;
  endfunction
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] dat);
    int k;
    k = 0;
    adr <= a;
    wr <= w;
    rd <= !w;
    wd <= dat;
    do begin
      @(posedge mclk_in);
      k++;
    end while (wt !== 1'b0 && k < 20);
    v = rdat;
    if (k >= 20) err_total++;
    rd <= 1'b0;
    wr <= 1'b0;
    @(posedge mclk_in);
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic hold(input logic lvl);
    h = 0;
    while (tmr === lvl && h < 3000) begin
      @(posedge mclk_in);
      h++;
    end
  endtask
  task automatic start(input logic [1:0] m, f, input logic iv, cs, input logic [1:0] src);
    bus(1'b1, ptm_pkg::ADDR_STATUS, 32'h3);
    bus(1'b1, ptm_pkg::ADDR_PERIOD, {16'h0, p});
    bus(1'b1, ptm_pkg::ADDR_DUTY, {16'h0, d});
    cw = ctl(m, f, iv, cs, src);
    bus(1'b1, ptm_pkg::ADDR_CTRL, cw);
  endtask
  task automatic stop;
    bus(1'b1, ptm_pkg::ADDR_CTRL, cw & ~32'h1);
    bus(1'b0, ptm_pkg::ADDR_STATUS, 32'h0);
  endtask
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    mclk_in = 1'b0;
    forever #25 mclk_in = ~mclk_in;
  end
  initial begin
    repeat (30000) @(posedge mclk_in);
    err_total++;
    give_verdict();
  end
  initial begin
    {seed, err_total, checked, rd, wr, adr, wd, oc} = {32'd74, 64'd0, 39'd0};
    {sys_rst_in, clk_en_in, tick_in} = 3'b111;
    repeat (12) @(posedge mclk_in);
    sys_rst_in <= 1'b0;
    @(posedge mclk_in);
    bus(1'b1, 4'hE, 32'hFFFFFFFF);
    for (i = 0; i < 16; i++) begin
      bus(1'b0, i[3:0], 32'h0);
      chk("reset value", 32'h0, v);
    end
    bus(1'b1, ptm_pkg::ADDR_PERIOD, 32'hFFFFFFFF);
    bus(1'b0, ptm_pkg::ADDR_PERIOD, 32'h0);
    chk("period width", 32'h3FF, v);
    $display("test registers done");
    p = 16'h0;
    for (i = 0; i < 4; i++) begin
      oc = 1'($random(seed));
      d = 16'd20 + 16'($random(seed) & 15);
      start(2'h0, i[1:0], 1'b0, 1'b0, 2'h0);
      @(posedge mclk_in);
      chk("initial pin", {31'h0, oc}, {31'h0, tmr});
      repeat (70) @(posedge mclk_in);
      stop();
      chk("compare status", {29'h0, ep(i[1:0], oc), 2'b01}, v);
    end
    for (i = 0; i < 2; i++) begin
      p = 16'd8 + 16'($random(seed) & 7);
      d = 16'd3;
      start(i ? 2'h3 : 2'h0, 2'h0, 1'b0, 1'b0, 2'h0);
      repeat (60) @(posedge mclk_in);
      if (i) chk("timer pin idle", 32'h0, {31'h0, tmr});
      stop();
      chk("both flags", 32'h3, v & 32'h3);
      bus(1'b0, ptm_pkg::ADDR_COUNT, 32'h0);
      chk("count below period", 32'h1, {31'h0, v < p});
    end
    {p, d} = {16'd4, 16'd12};
    start(2'h0, 2'h0, 1'b0, 1'b1, 2'h0);
    repeat (60) @(posedge mclk_in);
    stop();
    chk("duty clear flags", 32'h1, v & 32'h3);
    {p, d} = 32'h0;
    start(2'h0, 2'h0, 1'b0, 1'b0, 2'h0);
    repeat (1100) @(posedge mclk_in);
    tick_in <= 1'b0;
    bus(1'b0, ptm_pkg::ADDR_COUNT, 32'h0);
    c = v;
    repeat (20) @(posedge mclk_in);
    bus(1'b0, ptm_pkg::ADDR_COUNT, 32'h0);
    chk("count held", c, v);
    tick_in <= 1'b1;
    clk_en_in <= 1'b0;
    repeat (30) @(posedge mclk_in);
    clk_en_in <= 1'b1;
    stop();
    chk("overflow flags", 32'h2, v & 32'h3);
    $display("test compare done");
    for (i = 0; i < 5; i++) begin
      oc = i[0];
      p = (i == 4) ? 16'h0 : 16'd10 + 16'($random(seed) & 31);
      d = (i == 4) ? 16'd300 : 16'd1 + 16'($random(seed) & 7);
      t = (i == 4) ? 1024 : p;
      start(2'h2, 2'h2, i[1], 1'($random(seed)), 2'h0);
      hold(1'b1);
      hold(1'b0);
      hold(1'b1);
      n = h;
      hold(1'b0);
      chk("pwm period", 32'(t), 32'(n + h));
      chk("pwm active", (oc ^ i[1]) ? 32'(d) : 32'(t - d), 32'(n));
      stop();
      chk("pwm flags", 32'h3, v & 32'h3);
    end
    for (i = 0; i < 3; i++) begin
      {oc, p} = {1'b1, 16'd12};
      d = (i == 0) ? 16'd12 + 16'($random(seed) & 3) : 16'd5;
      start(2'h2, (i == 0) ? 2'h2 : i[1:0] - 2'h1, 1'b0, 1'b0, 2'h0);
      n = 0;
      repeat (24) begin
        @(posedge mclk_in);
        n += int'(tmr === 1'b1);
      end
      stop();
      chk("pwm level", (i == 1) ? 32'h0 : 32'd24, 32'(n));
      if (i > 0) chk("pwm flags kept", 32'h3, v & 32'h3);
    end
    $display("test pwm done");
    {oc, p, d} = {1'b1, 16'd5, 16'd20};
    start(2'h2, 2'h3, 1'b0, 1'b0, 2'h0);
    for (i = 0; i < 2; i++) begin
      chk("pulse lead", 32'h1, {31'h0, tmr});
      hold(1'b1);
      chk("pulse width", 32'h1, {31'h0, h >= 15 && h <= 22});
      chk("pulse irq", 32'h1, {31'h0, irq});
      bus(1'b0, ptm_pkg::ADDR_CTRL, 32'h0);
      chk("run cleared", 32'h0, v & 32'h1);
      bus(1'b1, ptm_pkg::ADDR_STATUS, 32'h3);
      u_ptm_pin_model.drive(1, i == 0, $random(seed) & 3);
      n = 0;
      while (tmr !== 1'b1 && n < 20) begin
        @(posedge mclk_in);
        n++;
      end
    end
    $display("test single pulse done");
    {p, d} = 32'h0;
    for (i = 0; i < 6; i++) begin
      t = (i < 4) ? 0 : i - 3;
      start(2'h1, (i < 4) ? i[1:0] : 2'h0, 1'b0, 1'b0, t[1:0]);
      repeat (20) @(posedge mclk_in);
      u_ptm_pin_model.drive(t, 1'b1, $random(seed) & 3);
      repeat (10) @(posedge mclk_in);
      bus(1'b0, ptm_pkg::ADDR_CAPTURE, 32'h0);
      c = v;
      bus(1'b0, ptm_pkg::ADDR_COUNT, 32'h0);
      n = (i == 1 || i == 3) ? 0 : 1;
      chk("capture irq", 32'(n), {31'h0, irq});
      if (n) chk("capture value", 32'h1, {31'h0, c >= 20 && c < v});
      stop();
      u_ptm_pin_model.drive(t, 1'b0, 0);
    end
    $display("test capture done");
    give_verdict();
  end
endmodule
`default_nettype wire
